// ### logic/cam_io_pkg.sv
// shared constants for trigger, exposure and output routing logic
// How it works
// R1 - pin one output picks one of seven signals by route low nibble, default trigger wait
// R2 - pin two output picks by route high nibble, same codes, default exposing flag
// R3 - user level code drives pin one from user bit 3, pin two from bit 4
// R4 - trigger wait low from accepted trigger until its readout ends, high otherwise
// R5 - triggers ignored while trigger wait low; trigger mask register unmasks them only during readout
// R6 - line aligned option defers exposure start to next line sync
// R7 - exposing flag high exactly while the sensor exposes
// R8 - raw trigger copy follows the synchronised trigger pin
// R9 - delayed trigger is the trigger level shifted by the configured delay
// R10 - readout window output equals frame valid
// R11 - pulse width mode exposes from trigger rise to trigger fall
// R12 - polarity selects which trigger level counts as active
// R13 - after exposure ends, frame output restarts at the next line sync
// R14 - in trigger modes frame valid appears only after a triggered exposure
// R15 - trigger pulses shorter than 30 pixel clocks are filtered out; bench also sends one shorter pulse
// R16 - exposure starts 105 pixel clocks after the qualifying trigger edge
// R17 - edge preset mode ends exposure after the stored shutter duration
// R18 - pixel clock counts are converted using a 27.1605 ns pixel clock period
// R19 - line sync repeats every 21.1852 us
// R20 - line aligned start lands within one line period after the fixed start latency
// R21 - trigger pin passes a two flip-flop synchroniser before filtering
package cam_io_pkg;
    localparam real CLK_NS = 8.0;
    localparam real PIX_CLK_NS = 27.1605; // R18
    localparam int FILTER_PIX = 30;
    localparam int START_PIX = 105;
    localparam real LINE_US = 21.1852;
    localparam real NS_PER_US = 1000.0;
    // least times round up, the period rounds down
    localparam int FILTER_CYC = int'($ceil(FILTER_PIX * PIX_CLK_NS / CLK_NS));
    localparam int START_CYC = int'($ceil(START_PIX * PIX_CLK_NS / CLK_NS));
    localparam int LINE_CYC = int'($floor(LINE_US * NS_PER_US / CLK_NS));
    localparam int LINE_W = $clog2(LINE_CYC);
    localparam int FRAME_LINES = 480;
    localparam int TRIG_DELAY_DEPTH = 1024;
    localparam int SHUTTER_W = 24;

    localparam logic [7:0] ADDR_ROUTE = 8'hf0;
    localparam logic [7:0] ADDR_USER = 8'hf1;
    localparam logic [7:0] ADDR_START_MODE = 8'h12;
    localparam logic [7:0] ADDR_TRIG_MASK = 8'h13;
    localparam logic [7:0] RST_ROUTE = 8'h20;
    localparam logic [7:0] RST_USER = 8'h00;
    localparam logic RST_LINE_ALIGN = 1'b0;
    localparam logic RST_ACCEPT_BUSY = 1'b0;
    localparam int CTRL_BIT = 0;
    localparam int USER_BIT_PIN1 = 3;
    localparam int USER_BIT_PIN2 = 4;

    localparam logic [3:0] SEL_TRIG_WAIT = 4'h0;
    localparam logic [3:0] SEL_USER = 4'h1;
    localparam logic [3:0] SEL_EXPOSING = 4'h2;
    localparam logic [3:0] SEL_RAW_TRIG = 4'h3;
    localparam logic [3:0] SEL_DELAYED_TRIG = 4'h4;
    localparam logic [3:0] SEL_READOUT = 4'h5;
    localparam logic [3:0] SEL_FLASH = 4'h6;

    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PULSE_WIDTH = 2'h1;
    localparam logic [1:0] MODE_EDGE_PRESET = 2'h2;
endpackage : cam_io_pkg

// ### logic/trig_glitch_filter.sv
// trigger pin synchroniser and glitch filter
`timescale 1ns/10ps
module trig_glitch_filter #(
    parameter int FILTER_CYC = cam_io_pkg::FILTER_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_pin,
    output logic o_sync,
    output logic o_level
);
    localparam int CW = $clog2(FILTER_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(FILTER_CYC - 1);

    typedef struct packed {
        logic meta;
        logic sync;
        logic level;
        logic [CW-1:0] cnt;
    } filt_t;

    filt_t s_ff;
    filt_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.meta = i_pin; // R21
        nxt_s.sync = s_ff.meta; // R21
        if (s_ff.sync != s_ff.level) begin
            // level moves only after a full filter width of agreement
            if (s_ff.cnt == CNT_LAST) begin
                nxt_s.level = s_ff.sync; // R15
                nxt_s.cnt = '0;
            end else begin
                nxt_s.cnt = s_ff.cnt + CW'(1);
            end
        end else begin
            nxt_s.cnt = '0; // R15
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign o_sync = s_ff.sync;
    assign o_level = s_ff.level;
endmodule : trig_glitch_filter

// ### logic/trig_tap_delay.sv
// tapped shift line delaying a single level
`timescale 1ns/10ps
module trig_tap_delay #(
    parameter int DEPTH = cam_io_pkg::TRIG_DELAY_DEPTH,
    parameter int TW = $clog2(DEPTH)
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_din,
    input wire logic [TW-1:0] i_tap,
    output logic o_dout
);
    typedef struct packed {
        logic [DEPTH-1:0] line;
    } tap_t;

    tap_t s_ff;
    tap_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.line = {s_ff.line[DEPTH-2:0], i_din};
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // tap k gives a delay of k+1 clocks
    assign o_dout = s_ff.line[i_tap];
endmodule : trig_tap_delay

// ### logic/camera_trigger_exposure_io.sv
// trigger, exposure sequencing and output pin routing of the camera
`timescale 1ns/10ps
module camera_trigger_exposure_io #(
    parameter int FILTER_CYC = cam_io_pkg::FILTER_CYC,
    parameter int START_CYC = cam_io_pkg::START_CYC,
    parameter int LINE_CYC = cam_io_pkg::LINE_CYC,
    parameter int FRAME_LINES = cam_io_pkg::FRAME_LINES,
    parameter int TRIG_DELAY_DEPTH = cam_io_pkg::TRIG_DELAY_DEPTH,
    parameter int SHUTTER_W = cam_io_pkg::SHUTTER_W
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_trig_pin,
    input wire logic [1:0] i_trig_mode,
    input wire logic i_trig_neg,
    input wire logic [SHUTTER_W-1:0] i_shutter_cycles,
    input wire logic [$clog2(TRIG_DELAY_DEPTH)-1:0] i_trig_delay,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_io1,
    output logic o_io2,
    output logic o_frame_valid,
    output logic o_line_sync
);
    localparam int LW = $clog2(LINE_CYC);
    localparam int FW = $clog2(FRAME_LINES);
    localparam int DW = $clog2(TRIG_DELAY_DEPTH);
    localparam int SW = $clog2(START_CYC);
    localparam logic [LW-1:0] LINE_LAST = LW'(LINE_CYC - 1);
    localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_LINES - 1);
    localparam logic [SW-1:0] START_TAP = SW'(START_CYC - 1);

    typedef enum logic [2:0] {
        EXP_IDLE,
        EXP_ARMED,
        EXP_ALIGN,
        EXP_ON,
        EXP_RESTART
    } exp_state_t;

    typedef struct packed {
        exp_state_t exp;
        logic [SHUTTER_W-1:0] exp_cnt;
        logic [LW-1:0] line_cnt;
        logic line_sync;
        logic readout;
        logic [FW-1:0] frame_line;
        logic trig_prev;
        logic start_prev;
        logic [7:0] route;
        logic [7:0] user;
        logic line_align;
        logic accept_busy;
        logic [7:0] rdata;
        logic io1;
        logic io2;
    } state_t;

    state_t s_ff;
    state_t nxt_s;

    logic raw_trig;
    logic filt_level;
    logic trig_act;
    logic start_act;
    logic delayed_trig;
    logic trig_mode;
    logic trig_rise;
    logic start_rise;
    logic accept;
    logic exposing;
    logic flash;
    logic wait_flag;

    // chooses the pin signal for a route code; test codes drive low
    function automatic logic route_pick(input logic [3:0] code, input logic [6:0] sigs);
        logic pick;
        pick = 1'b0;
        if (code <= cam_io_pkg::SEL_FLASH) begin
            pick = sigs[code[2:0]];
        end
        return pick;
    endfunction : route_pick

    trig_glitch_filter #(
        .FILTER_CYC(FILTER_CYC)
    ) u_filter (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pin(i_trig_pin),
        .o_sync(raw_trig),
        .o_level(filt_level)
    );

    assign trig_act = filt_level ^ i_trig_neg; // R12

    // fixed start latency line, fed with the active level
    trig_tap_delay #(
        .DEPTH(START_CYC),
        .TW(SW)
    ) u_start_delay (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_din(trig_act),
        .i_tap(START_TAP),
        .o_dout(start_act)
    );

    // user trigger delay for the delayed trigger pin signal
    trig_tap_delay #(
        .DEPTH(TRIG_DELAY_DEPTH),
        .TW(DW)
    ) u_user_delay (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_din(filt_level),
        .i_tap(i_trig_delay),
        .o_dout(delayed_trig)
    );

    assign trig_mode = (i_trig_mode == cam_io_pkg::MODE_PULSE_WIDTH)
        || (i_trig_mode == cam_io_pkg::MODE_EDGE_PRESET);
    assign trig_rise = trig_act && !s_ff.trig_prev;
    assign start_rise = start_act && !s_ff.start_prev; // R16
    // unmasked triggers may arrive while the last frame is still read out
    assign accept = trig_mode && trig_rise && (s_ff.exp == EXP_IDLE)
        && (!s_ff.readout || s_ff.accept_busy); // R5

    always_comb begin
        nxt_s = s_ff;
        nxt_s.trig_prev = trig_act;
        nxt_s.start_prev = start_act;

        // line sync timebase
        nxt_s.line_sync = 1'b0;
        if (s_ff.line_cnt == LINE_LAST) begin
            nxt_s.line_cnt = '0;
            nxt_s.line_sync = 1'b1; // R19
        end else begin
            nxt_s.line_cnt = s_ff.line_cnt + LW'(1);
        end

        // readout advances one line per line sync
        if (s_ff.readout && s_ff.line_sync) begin
            if (s_ff.frame_line == FRAME_LAST) begin
                nxt_s.readout = 1'b0;
                nxt_s.frame_line = '0;
            end else begin
                nxt_s.frame_line = s_ff.frame_line + FW'(1);
            end
        end

        unique case (s_ff.exp)
            EXP_IDLE: begin
                if (i_trig_mode == cam_io_pkg::MODE_NORMAL) begin
                    if (!s_ff.readout) begin
                        nxt_s.exp = EXP_ON;
                        nxt_s.exp_cnt = '0;
                    end
                end else if (accept) begin
                    nxt_s.exp = EXP_ARMED; // R4
                end
            end
            EXP_ARMED: begin
                if (start_rise) begin
                    nxt_s.exp_cnt = '0;
                    if (s_ff.line_align) begin
                        nxt_s.exp = EXP_ALIGN; // R6
                    end else begin
                        nxt_s.exp = EXP_ON; // R16
                    end
                end
            end
            EXP_ALIGN: begin
                if (s_ff.line_sync) begin
                    nxt_s.exp = EXP_ON; // R20
                end
            end
            EXP_ON: begin
                nxt_s.exp_cnt = s_ff.exp_cnt + SHUTTER_W'(1);
                if (i_trig_mode == cam_io_pkg::MODE_PULSE_WIDTH) begin
                    if (!start_act) begin
                        nxt_s.exp = EXP_RESTART; // R11
                    end
                end else if (s_ff.exp_cnt >= i_shutter_cycles) begin
                    nxt_s.exp = EXP_RESTART; // R17
                end
            end
            EXP_RESTART: begin
                if (s_ff.line_sync) begin
                    // vertical reset: frame output starts over
                    nxt_s.exp = EXP_IDLE;
                    nxt_s.readout = 1'b1; // R13 R14
                    nxt_s.frame_line = '0;
                end
            end
        endcase

        // register writes
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                cam_io_pkg::ADDR_ROUTE: nxt_s.route = i_reg_wdata;
                cam_io_pkg::ADDR_USER: nxt_s.user = i_reg_wdata;
                cam_io_pkg::ADDR_START_MODE: begin
                    nxt_s.line_align = i_reg_wdata[cam_io_pkg::CTRL_BIT]; // R6
                end
                cam_io_pkg::ADDR_TRIG_MASK: begin
                    nxt_s.accept_busy = i_reg_wdata[cam_io_pkg::CTRL_BIT]; // R5
                end
                default: begin
                end
            endcase
        end

        // register reads, unmapped reads return zero
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                cam_io_pkg::ADDR_ROUTE: nxt_s.rdata = s_ff.route;
                cam_io_pkg::ADDR_USER: nxt_s.rdata = s_ff.user;
                cam_io_pkg::ADDR_START_MODE: begin
                    nxt_s.rdata = '0;
                    nxt_s.rdata[cam_io_pkg::CTRL_BIT] = s_ff.line_align;
                end
                cam_io_pkg::ADDR_TRIG_MASK: begin
                    nxt_s.rdata = '0;
                    nxt_s.rdata[cam_io_pkg::CTRL_BIT] = s_ff.accept_busy;
                end
                default: nxt_s.rdata = '0;
            endcase
        end
    end

    // pin signals taken from the next state so pins and state share an edge
    assign exposing = (nxt_s.exp == EXP_ON); // R7
    assign flash = exposing;
    assign wait_flag = !trig_mode
        || ((nxt_s.exp == EXP_IDLE) && !nxt_s.readout); // R4

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_ff <= '0;
            s_ff.exp <= EXP_IDLE;
            s_ff.route <= cam_io_pkg::RST_ROUTE; // R1 R2
            s_ff.user <= cam_io_pkg::RST_USER;
            s_ff.line_align <= cam_io_pkg::RST_LINE_ALIGN;
            s_ff.accept_busy <= cam_io_pkg::RST_ACCEPT_BUSY; // R5
        end else begin
            s_ff <= nxt_s;
            s_ff.io1 <= route_pick(nxt_s.route[3:0],
                {flash, nxt_s.readout, delayed_trig, raw_trig, exposing,
                 nxt_s.user[cam_io_pkg::USER_BIT_PIN1], wait_flag}); // R1 R3 R8 R9 R10
            s_ff.io2 <= route_pick(nxt_s.route[7:4],
                {flash, nxt_s.readout, delayed_trig, raw_trig, exposing,
                 nxt_s.user[cam_io_pkg::USER_BIT_PIN2], wait_flag}); // R2 R3
        end
    end

    assign o_io1 = s_ff.io1;
    assign o_io2 = s_ff.io2;
    assign o_frame_valid = s_ff.readout; // R10
    assign o_line_sync = s_ff.line_sync;
    assign o_reg_rdata = s_ff.rdata;
endmodule : camera_trigger_exposure_io

// ### test/trig_source.sv
// external trigger source: one active pulse of a chosen width per fire
`timescale 1ns/10ps
module trig_source (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_fire,
    input wire logic i_neg,
    input wire logic [15:0] i_width,
    output logic o_pin
);
    logic [15:0] left_ff;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            left_ff <= 16'h0000;
        end else if (i_fire) begin
            left_ff <= i_width;
        end else if (left_ff != 16'h0000) begin
            left_ff <= left_ff - 16'h0001;
        end
    end
    // active level while counting, opposite level when idle
    assign o_pin = (left_ff != 16'h0000) ^ i_neg;
endmodule : trig_source

// ### test/camera_trigger_exposure_io_assertions.sv
// port checks for routing, trigger copy, frame restart and line timing
`timescale 1ns/10ps
module camera_trigger_exposure_io_assertions #(
    parameter int LINE_CYC = 32
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_trig_pin,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_io1,
    input wire logic o_io2,
    input wire logic o_frame_valid,
    input wire logic o_line_sync
);
    logic [7:0] route_ff;
    logic [7:0] user_ff;
    logic mask_ff;
    int ls_gap;
    // clocks since the last line sync pulse
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ls_gap <= 0;
        end else begin
            ls_gap <= o_line_sync ? 1 : ls_gap + 1;
        end
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            route_ff <= cam_io_pkg::RST_ROUTE;
            user_ff <= cam_io_pkg::RST_USER;
            mask_ff <= 1'b0;
        end else if (i_reg_wr) begin
            if (i_reg_addr == cam_io_pkg::ADDR_ROUTE) begin
                route_ff <= i_reg_wdata;
            end
            if (i_reg_addr == cam_io_pkg::ADDR_USER) begin
                user_ff <= i_reg_wdata;
            end
            if (i_reg_addr == cam_io_pkg::ADDR_TRIG_MASK) begin
                mask_ff <= i_reg_wdata[0];
            end
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_line_period: assert property (o_line_sync |-> ls_gap == LINE_CYC)
        else $error("line sync period wrong");
    a_frame_at_sync: assert property ($rose(o_frame_valid)
        |-> o_line_sync || $past(o_line_sync))
        else $error("frame start not at line sync");
    a_io1_user: assert property (route_ff[3:0] == cam_io_pkg::SEL_USER
        |-> o_io1 == user_ff[3])
        else $error("pin one user level wrong");
    a_io2_user: assert property (route_ff[7:4] == cam_io_pkg::SEL_USER
        |-> o_io2 == user_ff[4])
        else $error("pin two user level wrong");
    a_io_test_low: assert property (route_ff[3:0] > 4'h6 |-> !o_io1)
        else $error("test code pin not low");
    a_io2_readout: assert property (route_ff[7:4] == cam_io_pkg::SEL_READOUT
        |-> o_io2 == o_frame_valid)
        else $error("readout window differs from frame valid");
    a_raw_copy: assert property (route_ff[3:0] == cam_io_pkg::SEL_RAW_TRIG
        |-> o_io1 == $past(i_trig_pin, 3))
        else $error("raw trigger copy wrong");
    a_wait_idle: assert property ($fell(o_frame_valid) && !mask_ff
        && route_ff[3:0] == cam_io_pkg::SEL_TRIG_WAIT |-> ##[1:3] o_io1)
        else $error("wait flag not back high");
    a_route_read: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == cam_io_pkg::ADDR_ROUTE
        |=> o_reg_rdata == $past(route_ff))
        else $error("route readback wrong");
    c_frame: cover property ($rose(o_frame_valid));
    c_user: cover property (route_ff[3:0] == cam_io_pkg::SEL_USER && o_io1);
    c_raw: cover property (route_ff[3:0] == cam_io_pkg::SEL_RAW_TRIG && o_io1);
endmodule : camera_trigger_exposure_io_assertions
bind camera_trigger_exposure_io camera_trigger_exposure_io_assertions #(.LINE_CYC(LINE_CYC)) i_chk (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_trig_pin(i_trig_pin), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_io1(o_io1), .o_io2(o_io2),
    .o_frame_valid(o_frame_valid), .o_line_sync(o_line_sync));

// ### test/camera_trigger_exposure_io_tb_top.sv
// register and trigger sequence bench for the trigger and output block
`timescale 1ns/10ps
module camera_trigger_exposure_io_tb_top;
    localparam int F = 4, S = 8, L = 32, N = 4;
    logic i_clk = 1'b0, i_reset_n = 1'b0, pin, fire = 1'b0, neg = 1'b0;
    logic [1:0] mode = 2'h1;
    logic rd = 1'b0, wr = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [15:0] width = 16'h0028;
    logic io1, io2, fv, ls;
    int err_total = 0, n_checks = 0, n, t, since_ls = 0;
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    always @(negedge i_clk) since_ls <= ls ? 0 : since_ls + 1;
    trig_source i_src (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_fire(fire), .i_neg(neg),
        .i_width(width), .o_pin(pin));
    camera_trigger_exposure_io #(.FILTER_CYC(F), .START_CYC(S), .LINE_CYC(L), .FRAME_LINES(N),
        .TRIG_DELAY_DEPTH(16)) i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_trig_pin(pin),
        .i_trig_mode(mode), .i_trig_neg(neg), .i_shutter_cycles(24'h000014),
        .i_trig_delay(4'h5), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_io1(io1), .o_io2(io2),
        .o_frame_valid(fv), .o_line_sync(ls));
    task automatic conclude();
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic rng(input string what, input int lo, input int hi, input int v);
        n_checks++;
        if (v < lo || v > hi) begin
            err_total++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, v);
        end
    endtask : rng
    function automatic logic io(input int w);
        return w == 1 ? io1 : (w == 2 ? io2 : fv);
    endfunction : io
    task automatic await(input int w, input logic lvl, input int max, output int c);
        c = 0;
        while (io(w) !== lvl) begin
            @(negedge i_clk);
            c++;
            if (c > max) begin
                err_total++;
                $display("[FAIL] signal %0d expected %b seen %b", w, lvl, io(w));
                conclude();
            end
        end
    endtask : await
    task automatic span(input int w, input int cyc, output int c);
        c = 0;
        repeat (cyc) begin
            @(negedge i_clk);
            if (io(w) === 1'b1) c++;
        end
    endtask : span
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge i_clk);
        wr <= 1'b0;
        repeat (3) @(negedge i_clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_clk);
        rd <= 1'b0;
        @(negedge i_clk);
        chk("rdata", e, rdata);
    endtask : rd_reg
    task automatic shoot(input logic [15:0] wd);
        @(posedge i_clk);
        width <= wd;
        fire <= 1'b1;
        @(posedge i_clk);
        fire <= 1'b0;
    endtask : shoot
    initial begin
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd_reg(8'hf0, 8'h20);
        rd_reg(8'hf1, 8'h00);
        rd_reg(8'h55, 8'h00);
        for (int c = 0; c < 16; c++) begin
            wr_reg(8'hf0, {c[3:0], ~c[3:0]});
            rd_reg(8'hf0, {c[3:0], ~c[3:0]});
        end
        wr_reg(8'hf1, 8'h18);
        wr_reg(8'hf0, 8'h11);
        chk("io1 user", 8'h01, {7'h00, io1});
        chk("io2 user", 8'h01, {7'h00, io2});
        wr_reg(8'hf1, 8'h08);
        chk("io2 user low", 8'h00, {7'h00, io2});
        wr_reg(8'hf0, 8'h20);
        span(3, 3 * L, n);
        rng("frame valid before trigger", 0, 0, n);
        shoot(16'h0002);
        span(2, 40, n);
        rng("short pulse exposure", 0, 0, n);
        shoot(16'h0028);
        await(2, 1'b1, 60, t);
        rng("exposure start", F + S, F + S + 10, t);
        await(2, 1'b0, 60, n);
        rng("pulse exposure length", 38, 42, n);
        await(3, 1'b1, L + 4, t);
        chk("wait flag in readout", 8'h00, {7'h00, io1});
        shoot(16'h0028);
        await(3, 1'b0, N * L + 4, n);
        rng("frame length", N * L - 2, N * L + 2, n);
        span(3, 3 * L, n);
        rng("masked trigger frames", 0, 0, n);
        wr_reg(8'h13, 8'h01);
        // polarity flips with triggers off, so no false edge is taken
        @(posedge i_clk);
        mode <= 2'h3;
        neg <= 1'b1;
        span(1, 8, n);
        @(posedge i_clk);
        mode <= 2'h2;
        shoot(16'h0028);
        await(2, 1'b1, 60, t);
        await(2, 1'b0, 60, n);
        rng("preset exposure length", 20, 22, n);
        await(3, 1'b1, L + 4, t);
        shoot(16'h0028);
        await(2, 1'b1, 60, t);
        rng("unmasked start", F + S, F + S + 10, t);
        await(1, 1'b1, 4 * N * L, t);
        wr_reg(8'h12, 8'h01);
        shoot(16'h0028);
        await(2, 1'b1, F + S + L + 12, t);
        rng("aligned start", 0, 3, since_ls);
        await(1, 1'b1, 4 * N * L, t);
        @(posedge i_clk);
        mode <= 2'h3;
        neg <= 1'b0;
        span(1, 8, n);
        @(posedge i_clk);
        mode <= 2'h2;
        wr_reg(8'hf0, 8'h34);
        shoot(16'h0028);
        await(2, 1'b1, 10, t);
        await(1, 1'b1, F + 20, n);
        rng("delayed trigger lag", F + 5, F + 12, n);
        conclude();
    end
endmodule : camera_trigger_exposure_io_tb_top
